/* cpsw_defines.svh */
// Bit positions, reset values and address constants of the status word.
`ifndef CPSW_DEFINES_SVH
`define CPSW_DEFINES_SVH
`define CPSW_ILM_MSB 15
`define CPSW_ILM_LSB 13
`define CPSW_RP_MSB 12
`define CPSW_RP_LSB 8
`define CPSW_CCR_RSV 7
`define CPSW_BIT_I 6
`define CPSW_BIT_S 5
`define CPSW_BIT_T 4
`define CPSW_BIT_N 3
`define CPSW_BIT_Z 2
`define CPSW_BIT_V 1
`define CPSW_BIT_C 0
`define CPSW_ILM_RST 3'h0
`define CPSW_RP_RST 5'h00
`define CPSW_I_RST 1'b0
`define CPSW_S_RST 1'b1
`define CPSW_FLAG_RST 5'h00
`define CPSW_SP_RST 16'h0000
`define CPSW_BANK_RST 8'h00
`define CPSW_GPR_BASE 24'h000180
`define CPSW_GPR_LAST 24'h00037f
`define CPSW_GPR_SHIFT 4
`define CPSW_SP_STEP 16'h0002
`endif

/* cpsw_pkg.sv */
// Types shared by the status word block and its stack sequencer.
package cpsw_pkg;
  typedef enum logic [8:0] {
    WR_NONE = 9'h001,
    WR_PS = 9'h002,
    WR_ILM = 9'h004,
    WR_RP = 9'h008,
    WR_CCR = 9'h010,
    WR_USP = 9'h020,
    WR_SSP = 9'h040,
    WR_USB = 9'h080,
    WR_SSB = 9'h100
  } cpsw_wsel_e;

  typedef struct packed {
    cpsw_wsel_e sel;
    logic [15:0] data;
  } cpsw_wr_s;

  typedef enum logic [4:0] {
    OP_NONE = 5'h01,
    OP_ADD = 5'h02,
    OP_SUB = 5'h04,
    OP_SHR = 5'h08,
    OP_LOGIC = 5'h10
  } cpsw_op_e;

  typedef struct packed {
    cpsw_op_e kind;
    logic byte_op;
    logic arith;
    logic [15:0] a;
    logic [15:0] b;
  } cpsw_alu_s;

  typedef struct packed {
    logic [15:0] result;
    logic t;
    logic n;
    logic z;
    logic v;
    logic c;
    logic upd_t;
    logic upd_v;
    logic upd_c;
  } cpsw_flag_s;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h1,
    SEQ_FIRST = 3'h2,
    SEQ_SECOND = 3'h4
  } cpsw_seq_e;
endpackage

/* cpsw_stack_seq.sv */
// Stack access sequencer: one word access, or two byte accesses if odd.
`timescale 1ns/1ps
`default_nettype none
`include "cpsw_defines.svh"
module cpsw_stack_seq
  import cpsw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic push_i,
  input wire logic [15:0] sp_i,
  input wire logic [7:0] bank_i,
  input wire logic [15:0] wdata_i,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic mem_byte_o,
  output logic [23:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  output logic busy_o,
  output logic done_o,
  output logic [15:0] rdata_o,
  output logic [15:0] sp_o
);
  cpsw_seq_e state_q;
  logic [23:0] addr_q;
  logic [15:0] wdata_q, rdata_q, sp_q;
  logic odd_q, we_q, done_q;
  logic [15:0] acc_sp;

  // A push pre-decrements; a pop reads at the pointer itself.
  assign acc_sp = push_i ? sp_i - `CPSW_SP_STEP : sp_i;

  // Sequencer; an odd pointer costs a second byte access.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= SEQ_IDLE;
      addr_q <= 24'h000000;
      wdata_q <= 16'h0000;
      rdata_q <= 16'h0000;
      sp_q <= 16'h0000;
      odd_q <= 1'b0;
      we_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce_i) begin
      done_q <= 1'b0;
      case (state_q)
        SEQ_IDLE: begin
          if (start_i) begin
            state_q <= SEQ_FIRST;
            addr_q <= {bank_i, acc_sp};
            odd_q <= acc_sp[0];
            we_q <= push_i;
            wdata_q <= wdata_i;
            sp_q <= push_i ? acc_sp : sp_i + `CPSW_SP_STEP;
          end
        end
        SEQ_FIRST: begin
          if (mem_ack_i) begin
            if (odd_q) begin
              rdata_q[7:0] <= mem_rdata_i[7:0];
              addr_q[15:0] <= addr_q[15:0] + 16'h0001;
              wdata_q <= {8'h00, wdata_q[15:8]};
              state_q <= SEQ_SECOND;
            end else begin
              rdata_q <= mem_rdata_i;
              state_q <= SEQ_IDLE;
              done_q <= 1'b1;
            end
          end
        end
        SEQ_SECOND: begin
          if (mem_ack_i) begin
            rdata_q[15:8] <= mem_rdata_i[7:0];
            state_q <= SEQ_IDLE;
            done_q <= 1'b1;
          end
        end
        default: state_q <= SEQ_IDLE;
      endcase
    end
  end

  // The done cycle counts as busy so the pointer write-back lands first.
  assign mem_req_o = (state_q != SEQ_IDLE);
  assign busy_o = mem_req_o || done_q;
  assign mem_we_o = we_q;
  assign mem_byte_o = odd_q;
  assign mem_addr_o = addr_q;
  assign mem_wdata_o = wdata_q;
  assign done_o = done_q;
  assign rdata_o = rdata_q;
  assign sp_o = sp_q;
endmodule
`default_nettype wire

/* cpsw_status_word.sv */
// Processor status word with flag unit, interrupt gate and stack select.
`timescale 1ns/1ps
`default_nettype none
`include "cpsw_defines.svh"
// Operation
// - Status word: mask in bits 15-13, bank pointer 12-8, flags in low byte.
// - Interrupt enable 1 admits hardware requests, 0 refuses; reset clears.
// - Stack select 0 uses user stack pointer, 1 the system one.
// - Reset and every accepted interrupt force stack select to 1.
// - Program counter pushed on interrupt or call, popped on return.
// - Odd stack pointer splits each word access into two byte accesses.
// - Right shift sets sticky if any bit past carry was 1.
// - Negative flag takes the result's top bit.
// - Zero flag set exactly when all result bits are zero.
// - Overflow flag set on signed overflow, else cleared.
// - Carry flag set on carry out or borrow, else cleared.
// - Bank pointer is five bits, banks 00H to 1FH.
// - Selected bank start lies within 000180H to 00037FH.
// - Bank start equals 000180H plus pointer times 10H.
// - Byte write to bank pointer keeps its low five bits.
// - Reset clears the bank pointer to 00H.
// - Accept request only if enabled and its level below the mask.
// - Accepting loads the mask with the accepted request's level.
// - Reset clears the mask to zero, blocking every maskable request.
// - Byte write to the mask keeps its low three bits.
// - Stack address top byte from user bank or system bank by select.
module cpsw_status_word
  import cpsw_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire cpsw_wr_s WR_I,
  input wire cpsw_alu_s ALU_I,
  input wire logic HW_REQ_I,
  input wire logic [2:0] REQ_LEVEL_I,
  input wire logic SW_INT_I,
  input wire logic CALL_I,
  input wire logic RET_I,
  input wire logic [15:0] PC_I,
  input wire logic STK_ACK_I,
  input wire logic [15:0] STK_RDATA_I,
  output logic [15:0] RESULT_O,
  output logic INT_ACK_O,
  output logic BUSY_O,
  output logic RET_VALID_O,
  output logic [15:0] RET_PC_O,
  output logic [15:0] PS_O,
  output logic [23:0] ACTIVE_SP_O,
  output logic [23:0] BANK_BASE_O,
  output logic STK_REQ_O,
  output logic STK_WE_O,
  output logic STK_BYTE_O,
  output logic [23:0] STK_ADDR_O,
  output logic [15:0] STK_WDATA_O
);
  logic [2:0] ilm_q;
  logic [4:0] rp_q;
  logic i_q, s_q, t_q, n_q, z_q, v_q, c_q;
  logic [15:0] usp_q, ssp_q, result_q, ret_pc_q;
  logic [7:0] usb_q, ssb_q;
  logic int_ack_q, ret_valid_q, use_sys_q, pop_q;
  logic seq_busy, seq_done;
  logic [15:0] seq_sp, seq_rdata;
  logic hw_take, sw_take, call_take, ret_take, start, use_sys;
  logic ccr_wr;
  logic [7:0] ccr_data;
  cpsw_flag_s flg;

  // Evaluates one operation and the flags it produces. Byte operands sit
  // in the upper byte so the 16-bit adder yields byte carry and overflow.
  function automatic cpsw_flag_s alu_eval(input cpsw_alu_s op);
    logic [15:0] x, y, top;
    logic [16:0] w;
    logic [31:0] sh;
    cpsw_flag_s f;
    x = op.byte_op ? {op.a[7:0], 8'h00} : op.a;
    y = op.byte_op ? {op.b[7:0], 8'h00} : op.b;
    f = '0;
    w = (op.kind == OP_SUB) ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
    if (op.arith) begin
      sh = $signed({x, 16'h0000}) >>> op.b[3:0];
    end else begin
      sh = {x, 16'h0000} >> op.b[3:0];
    end
    case (op.kind)
      OP_ADD, OP_SUB: begin
        top = w[15:0];
        f.c = w[16];
        if (op.kind == OP_SUB) begin
          f.v = (x[15] != y[15]) && (top[15] != x[15]);
        end else begin
          f.v = (x[15] == y[15]) && (top[15] != x[15]);
        end
        f.upd_v = 1'b1;
        f.upd_c = 1'b1;
      end
      OP_SHR: begin
        top = op.byte_op ? {sh[31:24], 8'h00} : sh[31:16];
        f.c = op.byte_op ? sh[23] : sh[15];
        f.t = op.byte_op ? |sh[22:0] : |sh[14:0];
        f.upd_t = 1'b1;
        f.upd_c = 1'b1;
      end
      OP_LOGIC: begin
        top = x;
        f.v = 1'b0;
        f.upd_v = 1'b1;
      end
      default: top = 16'h0000;
    endcase
    f.n = top[15];
    f.z = (top == 16'h0000);
    f.result = op.byte_op ? {8'h00, top[15:8]} : top;
    return f;
  endfunction

  assign flg = alu_eval(ALU_I);
  assign ccr_wr = (WR_I.sel == WR_CCR) || (WR_I.sel == WR_PS);
  assign ccr_data = WR_I.data[7:0];

  // Arbitration; stack work is one at a time, so requests wait while busy.
  // A hardware request is a level that the source holds until acknowledged.
  always_comb begin
    hw_take = CE_I && !seq_busy && HW_REQ_I && i_q
      && (REQ_LEVEL_I < ilm_q);
    sw_take = CE_I && !seq_busy && !hw_take && SW_INT_I;
    call_take = CE_I && !seq_busy && !hw_take && !sw_take && CALL_I;
    ret_take = CE_I && !seq_busy && !hw_take && !sw_take && !call_take
      && RET_I;
    start = hw_take || sw_take || call_take || ret_take;
    use_sys = hw_take || sw_take || s_q;
  end

  cpsw_stack_seq u_seq (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .start_i(start),
    .push_i(!ret_take),
    .sp_i(use_sys ? ssp_q : usp_q),
    .bank_i(use_sys ? ssb_q : usb_q),
    .wdata_i(PC_I),
    .mem_ack_i(STK_ACK_I),
    .mem_rdata_i(STK_RDATA_I),
    .mem_req_o(STK_REQ_O),
    .mem_we_o(STK_WE_O),
    .mem_byte_o(STK_BYTE_O),
    .mem_addr_o(STK_ADDR_O),
    .mem_wdata_o(STK_WDATA_O),
    .busy_o(seq_busy),
    .done_o(seq_done),
    .rdata_o(seq_rdata),
    .sp_o(seq_sp)
  );

  // Interrupt level mask; acceptance outranks a software write.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ilm_q <= `CPSW_ILM_RST;
    end else if (CE_I) begin
      if (hw_take) begin
        ilm_q <= REQ_LEVEL_I;
      end else if (WR_I.sel == WR_ILM) begin
        ilm_q <= WR_I.data[2:0];
      end else if (WR_I.sel == WR_PS) begin
        ilm_q <= WR_I.data[`CPSW_ILM_MSB:`CPSW_ILM_LSB];
      end
    end
  end

  // Register bank pointer, five bits wide.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rp_q <= `CPSW_RP_RST;
    end else if (CE_I) begin
      if (WR_I.sel == WR_RP) begin
        rp_q <= WR_I.data[4:0];
      end else if (WR_I.sel == WR_PS) begin
        rp_q <= WR_I.data[`CPSW_RP_MSB:`CPSW_RP_LSB];
      end
    end
  end

  // Enable and stack select; an accepted interrupt wins over a write so
  // the handler can never start on the user stack.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      i_q <= `CPSW_I_RST;
      s_q <= `CPSW_S_RST;
    end else if (CE_I) begin
      if (ccr_wr) begin
        i_q <= ccr_data[`CPSW_BIT_I];
      end
      if (hw_take || sw_take) begin
        s_q <= 1'b1;
      end else if (ccr_wr) begin
        s_q <= ccr_data[`CPSW_BIT_S];
      end
    end
  end

  // Result flags. They are cleared at reset only for clean simulation;
  // software must treat them as unknown until first updated.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      {t_q, n_q, z_q, v_q, c_q} <= `CPSW_FLAG_RST;
      result_q <= 16'h0000;
    end else if (CE_I) begin
      if (ALU_I.kind != OP_NONE) begin
        result_q <= flg.result;
        n_q <= flg.n;
        z_q <= flg.z;
        if (flg.upd_t) t_q <= flg.t;
        if (flg.upd_v) v_q <= flg.v;
        if (flg.upd_c) c_q <= flg.c;
      end else if (ccr_wr) begin
        t_q <= ccr_data[`CPSW_BIT_T];
        n_q <= ccr_data[`CPSW_BIT_N];
        z_q <= ccr_data[`CPSW_BIT_Z];
        v_q <= ccr_data[`CPSW_BIT_V];
        c_q <= ccr_data[`CPSW_BIT_C];
      end
    end
  end

  // Stack pointers and banks; a finished sequence writes the pointer it
  // used, and that write-back beats a software write in the same cycle.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      usp_q <= `CPSW_SP_RST;
      ssp_q <= `CPSW_SP_RST;
      usb_q <= `CPSW_BANK_RST;
      ssb_q <= `CPSW_BANK_RST;
    end else if (CE_I) begin
      if (seq_done && !use_sys_q) begin
        usp_q <= seq_sp;
      end else if (WR_I.sel == WR_USP) begin
        usp_q <= WR_I.data;
      end
      if (seq_done && use_sys_q) begin
        ssp_q <= seq_sp;
      end else if (WR_I.sel == WR_SSP) begin
        ssp_q <= WR_I.data;
      end
      if (WR_I.sel == WR_USB) usb_q <= WR_I.data[7:0];
      if (WR_I.sel == WR_SSB) ssb_q <= WR_I.data[7:0];
    end
  end

  // Sequence bookkeeping, acknowledge pulse and returned address.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      use_sys_q <= 1'b0;
      pop_q <= 1'b0;
      int_ack_q <= 1'b0;
      ret_valid_q <= 1'b0;
      ret_pc_q <= 16'h0000;
    end else if (CE_I) begin
      if (start) begin
        use_sys_q <= use_sys;
        pop_q <= ret_take;
      end
      int_ack_q <= hw_take;
      ret_valid_q <= seq_done && pop_q;
      if (seq_done && pop_q) ret_pc_q <= seq_rdata;
    end
  end

  // Status word assembly; bit 7 is reserved and reads zero.
  always_comb begin
    PS_O = 16'h0000;
    PS_O[`CPSW_ILM_MSB:`CPSW_ILM_LSB] = ilm_q;
    PS_O[`CPSW_RP_MSB:`CPSW_RP_LSB] = rp_q;
    PS_O[`CPSW_BIT_I] = i_q;
    PS_O[`CPSW_BIT_S] = s_q;
    PS_O[`CPSW_BIT_T] = t_q;
    PS_O[`CPSW_BIT_N] = n_q;
    PS_O[`CPSW_BIT_Z] = z_q;
    PS_O[`CPSW_BIT_V] = v_q;
    PS_O[`CPSW_BIT_C] = c_q;
  end

  // Active stack address and the bank start of the register file.
  assign ACTIVE_SP_O = s_q ? {ssb_q, ssp_q} : {usb_q, usp_q};
  assign BANK_BASE_O = `CPSW_GPR_BASE
    + {15'h0000, rp_q, 4'h0};
  assign RESULT_O = result_q;
  assign INT_ACK_O = int_ack_q;
  assign BUSY_O = seq_busy;
  assign RET_VALID_O = ret_valid_q;
  assign RET_PC_O = ret_pc_q;

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);

  a_mask_on_accept: assert property (
    hw_take |=> ilm_q == $past(REQ_LEVEL_I) && INT_ACK_O)
    else $error("mask not loaded with accepted level");

  a_accept_gate: assert property (
    hw_take |-> PS_O[`CPSW_BIT_I] && REQ_LEVEL_I < PS_O[15:13])
    else $error("request accepted against enable or mask");

  a_sys_stack_irq: assert property (
    (hw_take || sw_take) |=> s_q ##1 !STK_REQ_O
      || STK_ADDR_O[23:16] == ssb_q)
    else $error("interrupt not moved to system stack");

  a_bank_byte_wr: assert property (
    CE_I && WR_I.sel == WR_RP |=> PS_O[12:8] == $past(WR_I.data[4:0]))
    else $error("bank pointer byte write wrong");

  a_mask_byte_wr: assert property (
    CE_I && !hw_take && WR_I.sel == WR_ILM
      |=> PS_O[15:13] == $past(WR_I.data[2:0]))
    else $error("mask byte write wrong");

  a_bank_range: assert property (
    BANK_BASE_O >= `CPSW_GPR_BASE && BANK_BASE_O <= `CPSW_GPR_LAST
      && BANK_BASE_O[3:0] == 4'h0)
    else $error("register bank start out of range");

  a_zero_neg_flag: assert property (
    CE_I && ALU_I.kind != OP_NONE |=> PS_O[`CPSW_BIT_Z] == (RESULT_O == 0)
      && PS_O[`CPSW_BIT_N] == ($past(ALU_I.byte_op) ? RESULT_O[7]
      : RESULT_O[15]))
    else $error("zero or negative flag disagrees with result");

  a_sticky_zero_amt: assert property (
    CE_I && ALU_I.kind == OP_SHR && ALU_I.b[3:0] == 4'h0
      |=> !PS_O[`CPSW_BIT_T] && !PS_O[`CPSW_BIT_C])
    else $error("zero shift left sticky or carry set");

  a_stack_select: assert property (
    ACTIVE_SP_O[23:16] == (PS_O[`CPSW_BIT_S] ? ssb_q : usb_q))
    else $error("stack bank does not follow select flag");

  a_odd_split: assert property (
    $rose(STK_REQ_O) && STK_ADDR_O[0] |-> STK_BYTE_O)
    else $error("odd stack access not split");
endmodule
`default_nettype wire

/* cpsw_stack_mem.sv */
// Behavioural stack memory that answers the status word block's accesses.
`timescale 1ns/1ps
`default_nettype none
module cpsw_stack_mem (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic byte_i,
  input wire logic [23:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [3:0] lat_i,
  output logic ack_o,
  output logic [15:0] rdata_o
);
  logic [7:0] mem [256];
  logic [3:0] wait_q;

  // Writes land on the edge that samples the acknowledge, little endian.
  always @(posedge clk_i) begin
    if (req_i && ack_o && we_i) begin
      mem[addr_i[7:0]] <= wdata_i[7:0];
      if (!byte_i) begin
        mem[addr_i[7:0] + 8'h01] <= wdata_i[15:8];
      end
    end
  end

  // Acknowledge after lat_i idle cycles. Outside an acknowledge the read
  // data flips every cycle, so a sample taken at the wrong time cannot pass.
  initial begin
    ack_o = 1'b0;
    rdata_o = 16'h0000;
    wait_q = 4'h0;
  end
  always @(negedge clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (req_i && !ack_o) begin
      if (wait_q >= lat_i) begin
        ack_o <= 1'b1;
        wait_q <= 4'h0;
        rdata_o <= {mem[addr_i[7:0] + 8'h01], mem[addr_i[7:0]]};
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* cpu_processor_status_word_bench.sv */
// Self-checking bench for the processor status word block.
`timescale 1ns/1ps
`default_nettype none
module cpu_processor_status_word_bench
  import cpsw_pkg::*;
;
  logic clk, rst_n, ce, hw_req, sw_int, call, ret, ack, int_ack, busy, rvalid;
  logic req, we, bacc;
  logic [2:0] lvl;
  logic [3:0] lat;
  logic [15:0] pc, rdata, result, ps, ret_pc, wdata;
  logic [23:0] asp, base, addr;
  cpsw_wr_s wr;
  cpsw_alu_s alu;
  int fail_count, checks;
  logic [31:0] log_a[$];
  logic [15:0] log_d[$];

  cpsw_status_word uut (.REF_CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
    .WR_I(wr), .ALU_I(alu), .HW_REQ_I(hw_req), .REQ_LEVEL_I(lvl),
    .SW_INT_I(sw_int), .CALL_I(call), .RET_I(ret), .PC_I(pc),
    .STK_ACK_I(ack), .STK_RDATA_I(rdata), .RESULT_O(result),
    .INT_ACK_O(int_ack), .BUSY_O(busy), .RET_VALID_O(rvalid),
    .RET_PC_O(ret_pc), .PS_O(ps), .ACTIVE_SP_O(asp), .BANK_BASE_O(base),
    .STK_REQ_O(req), .STK_WE_O(we), .STK_BYTE_O(bacc),
    .STK_ADDR_O(addr), .STK_WDATA_O(wdata));

  cpsw_stack_mem mem (.clk_i(clk), .req_i(req), .we_i(we), .byte_i(bacc),
    .addr_i(addr), .wdata_i(wdata), .lat_i(lat), .ack_o(ack),
    .rdata_o(rdata));

  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Every completed stack access is logged as {byte, write, address}.
  always @(posedge clk) begin
    if (req === 1'b1 && ack === 1'b1) begin
      log_a.push_back({6'h00, bacc, we, addr});
      log_d.push_back(wdata);
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // A hang is reported once and cut short, never waited out.
  task automatic hung(input string what);
    fail_count++;
    $display("mismatch at %0t: %s hung", $time, what);
    tally_and_finish();
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0) begin
      @(negedge clk);
      n++;
      if (n > 60) hung("stack sequence");
    end
  endtask

  task automatic wreg(input cpsw_wsel_e sel, input logic [15:0] d);
    @(negedge clk);
    wr = '{sel, d};
    @(negedge clk);
    wr = '{WR_NONE, 16'h0000};
  endtask

  // Which: 0 call, 1 return, 2 software interrupt.
  task automatic pulse(input int which);
    @(negedge clk);
    call = (which == 0);
    ret = (which == 1);
    sw_int = (which == 2);
    @(negedge clk);
    call = 1'b0;
    ret = 1'b0;
    sw_int = 1'b0;
    wait_idle();
  endtask

  // Mode ba: bit 1 selects a byte operation, bit 0 an arithmetic shift.
  task automatic op(input cpsw_op_e k, input logic [1:0] ba,
                    input logic [15:0] a,
                    input logic [15:0] b, input logic [15:0] res,
                    input logic [4:0] fl, input logic [4:0] m);
    @(negedge clk);
    alu = '{k, ba[1], ba[0], a, b};
    @(negedge clk);
    alu.kind = OP_NONE;
    chk({16'h0000, result}, {16'h0000, res}, "result");
    chk({27'h0, ps[4:0] & m}, {27'h0, fl & m}, "flags");
  endtask

  // The request is held four cycles, so a wrong second accept shows too.
  task automatic irq(input logic [2:0] level, input int exp);
    int n;
    n = 0;
    @(negedge clk);
    hw_req = 1'b1;
    lvl = level;
    repeat (4) begin
      @(negedge clk);
      if (int_ack === 1'b1) n++;
    end
    hw_req = 1'b0;
    wait_idle();
    chk(32'(n), 32'(exp), "accepts");
  endtask

  task automatic t_reset();
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    chk({16'h0000, ps} & 32'hffe0, 32'h20, "reset");
    chk(32'($isunknown(ps[4:0])), 32'h0, "reset flags");
    chk({8'h00, base}, 32'h180, "reset base");
    rst_n = 1'b1;
    $display("test reset done");
  endtask

  task automatic t_regs();
    wreg(WR_RP, 16'h00ff);
    chk({27'h0, ps[12:8]}, 32'h1f, "bank pointer");
    chk({8'h00, base}, 32'h370, "bank base");
    wreg(WR_ILM, 16'h00fd);
    chk({29'h0, ps[15:13]}, 32'h5, "mask");
    wreg(WR_PS, 16'hffff);
    chk({16'h0000, ps}, 32'hff7f, "whole word");
    $display("test regs done");
  endtask

  task automatic t_alu();
    op(OP_ADD, 2'b00, 16'h7fff, 16'h0001, 16'h8000, 5'h0a, 5'h0f);
    op(OP_ADD, 2'b00, 16'hffff, 16'h0001, 16'h0000, 5'h05, 5'h0f);
    op(OP_SUB, 2'b00, 16'h0000, 16'h0001, 16'hffff, 5'h09, 5'h0f);
    op(OP_SHR, 2'b00, 16'h0007, 16'h0002, 16'h0001, 5'h11, 5'h11);
    op(OP_SHR, 2'b00, 16'h0006, 16'h0002, 16'h0001, 5'h01, 5'h11);
    op(OP_SHR, 2'b00, 16'h00ff, 16'h0000, 16'h00ff, 5'h00, 5'h11);
    op(OP_LOGIC, 2'b00, 16'h0000, 16'h0000, 16'h0000, 5'h04, 5'h0e);
    op(OP_ADD, 2'b10, 16'h3480, 16'h5680, 16'h0000, 5'h07, 5'h0f);
    op(OP_SHR, 2'b11, 16'h1281, 16'h0001, 16'h00c0, 5'h09, 5'h1d);
    $display("test alu done");
  endtask

  // A low enable freezes everything, a pending write and operation too.
  task automatic t_ce();
    @(negedge clk);
    ce = 1'b0;
    wr = '{WR_RP, 16'h0003};
    alu = '{OP_ADD, 1'b0, 1'b0, 16'h0001, 16'h0001};
    repeat (2) @(negedge clk);
    chk({16'h0000, ps}, 32'hff7f, "frozen word");
    chk({16'h0000, result}, 32'h0000, "frozen result");
    wr = '{WR_NONE, 16'h0000};
    alu.kind = OP_NONE;
    ce = 1'b1;
    @(negedge clk);
    $display("test enable done");
  endtask

  // Software interrupt with the enable flag clear still goes through.
  task automatic t_sw();
    wreg(WR_CCR, 16'h0000);
    wreg(WR_SSB, 16'h0056);
    wreg(WR_SSP, 16'h1234);
    wreg(WR_USB, 16'h00c6);
    wreg(WR_USP, 16'hf328);
    chk({8'h00, asp}, 32'hc6f328, "user stack");
    log_a.delete();
    pc = 16'hbeef;
    pulse(2);
    chk({31'h0, ps[5]}, 32'h1, "stack flag");
    chk(log_a[0], 32'h01561232, "push address");
    chk({16'h0000, log_d[0]}, 32'hbeef, "push data");
    chk({8'h00, asp}, 32'h561232, "system stack");
    chk({29'h0, ps[15:13]}, 32'h7, "mask kept");
    $display("test swint done");
  endtask

  task automatic t_irq();
    irq(3'h2, 0);
    wreg(WR_CCR, 16'h0040);
    wreg(WR_ILM, 16'h0004);
    irq(3'h4, 0);
    log_a.delete();
    log_d.delete();
    pc = 16'h1357;
    irq(3'h3, 1);
    chk({29'h0, ps[15:13]}, 32'h3, "new mask");
    chk({31'h0, ps[5]}, 32'h1, "stack flag");
    chk(log_a[0], 32'h01561230, "push address");
    chk({16'h0000, log_d[0]}, 32'h1357, "push data");
    irq(3'h3, 0);
    $display("test irq done");
  endtask

  // Odd user pointer with a slow memory: every word splits into bytes.
  task automatic t_odd();
    int n;
    wreg(WR_CCR, 16'h0040);
    wreg(WR_USP, 16'h2001);
    lat = 4'h2;
    log_a.delete();
    log_d.delete();
    pc = 16'ha55a;
    pulse(0);
    chk(32'(log_a.size()), 32'h2, "access count");
    chk(log_a[0], 32'h03c61fff, "low byte address");
    chk(log_a[1], 32'h03c62000, "high byte address");
    chk({16'h0000, log_d[0][7:0], log_d[1][7:0]}, 32'h5aa5, "bytes");
    chk({8'h00, asp}, 32'hc61fff, "user pointer");
    @(negedge clk);
    ret = 1'b1;
    @(negedge clk);
    ret = 1'b0;
    n = 0;
    while (rvalid !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 60) hung("return");
    end
    chk({16'h0000, ret_pc}, 32'ha55a, "return pc");
    wait_idle();
    chk({8'h00, asp}, 32'hc62001, "pointer back");
    $display("test odd done");
  endtask

  // Main sequence; a second reset in mid-run closes it.
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    hw_req = 1'b0;
    sw_int = 1'b0;
    call = 1'b0;
    ret = 1'b0;
    lvl = 3'h0;
    lat = 4'h0;
    pc = 16'h0000;
    fail_count = 0;
    checks = 0;
    wr = '{WR_NONE, 16'h0000};
    alu = '{OP_NONE, 1'b0, 1'b0, 16'h0000, 16'h0000};
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_regs();
    t_ce();
    t_alu();
    t_sw();
    t_irq();
    t_odd();
    t_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
